// ---- dpio_defines.svh ----
/*
  Register addresses, field positions, reset values and widths for the dual pin port.
  Assumes it is included by its bare name from the package and the design modules.
*/
`ifndef DPIO_DEFINES_SVH
`define DPIO_DEFINES_SVH

// ****************************************************************
// Register addresses (9-bit register file address).
// ****************************************************************
`define DPIO_ADDR_W 9
`define DPIO_ADDR_BIDIR_DATA 9'h007
`define DPIO_ADDR_BIDIR_DIR 9'h087
`define DPIO_ADDR_INPUT_DATA 9'h107
`define DPIO_ADDR_SEG_ENABLE 9'h10D
`define DPIO_ADDR_INPUT_DIR 9'h187

// ****************************************************************
// Widths and reset values.
// ****************************************************************
`define DPIO_BIDIR_W 6
`define DPIO_INPUT_W 8
`define DPIO_RST_BIDIR_DIR 6'h3F
`define DPIO_RST_BIDIR_LATCH 6'h00
`define DPIO_RST_INPUT_DIR 8'hFF
`define DPIO_RST_SEG_ENABLE 8'hFF

// ****************************************************************
// Field positions.
// ****************************************************************
`define DPIO_SEG_LOW_BIT 3
`define DPIO_SEG_HIGH_BIT 4
`define DPIO_PIN_TMR_CKI 0
`define DPIO_PIN_TMR_OSI 1
`define DPIO_PIN_CCP 2
`define DPIO_PIN_SCK 3
`define DPIO_PIN_SDI 4
`define DPIO_PIN_SDO 5

`endif

// ---- dpio_pkg.sv ----
/*
  Types shared by the dual pin port design.
  Assumes dpio_defines.svh is on the include path.
*/
`default_nettype none

package dpio_pkg;
  `include "dpio_defines.svh"

  // ****************************************************************
  // Writing operations offered to the core.
  // ****************************************************************
  typedef enum logic [1:0] {
    DPIO_OP_WRITE = 2'b00,
    DPIO_OP_SET = 2'b01,
    DPIO_OP_CLEAR = 2'b10,
    DPIO_OP_TOGGLE = 2'b11
  } dpio_op_t;
endpackage : dpio_pkg

`default_nettype wire

// ---- dpio_rmw_alu.sv ----
/*
  Modify stage of the read-modify-write path: combines the value read back with the operand.
  Assumes the caller supplies the read value already chosen for the addressed register.
*/
`timescale 1ns/10ps
`default_nettype none

module dpio_rmw_alu #(
  parameter int W = 8
) (
  // Operation and operands.
  input wire dpio_pkg::dpio_op_t i_op,
  input wire logic [W-1:0] i_src,
  input wire logic [W-1:0] i_operand,
  input wire logic [2:0] i_bit,
  // Whole result to write back.
  output logic [W-1:0] o_result
);
  import dpio_pkg::*;

  logic [W-1:0] mask;

  // One-hot mask for the set and clear operations.
  assign mask = {{(W-1){1'b0}}, 1'b1} << i_bit;

  // A plain write ignores the read value; set and clear keep the other bits as read, toggle flips the read bits where the operand has ones.
  always_comb
  begin
    case (i_op)
      DPIO_OP_WRITE: o_result = i_operand;
      DPIO_OP_SET: o_result = i_src | mask;
      DPIO_OP_CLEAR: o_result = i_src & ~mask;
      DPIO_OP_TOGGLE: o_result = i_src ^ i_operand;
      default: o_result = i_operand;
    endcase
  end
endmodule : dpio_rmw_alu

`default_nettype wire

// ---- dpio_port.sv ----
/*
  Dual pin port: a six-pin bidirectional port with peripheral overrides and an eight-pin
  input-only port shared with segment drivers, reached through the core register file port.
  Assumes pin inputs are synchronous to i_clk_sys and that the core issues at most one
  register access per cycle.
*/
// Functional notes
// - The bidirectional port has six pins, each with its own direction bit.
// - An enabled peripheral forces its pin direction regardless of the direction bit.
// - The bidirectional direction register at 87h resets to ones on any reset; the data latch at 07h holds over non-power-on resets.
// - The two upper bits of the bidirectional port registers always read zero.
// - Bits 0-1 serve the timer oscillator, bit 2 capture/compare/PWM, bits 3-5 serial clock, data in and data out.
// - A direction bit of one makes a pin an input and zero makes it an output.
// - The eight-pin port is digital input only, each pin shared with a segment driver.
// - Power-on reset sets the segment enable register at 10Dh to all ones, giving pins to the segment drivers.
// - A set segment enable overrides the direction bits and the pin reads digitally only when cleared.
// - Input pins 0 to 7 pair in order with segment drivers 12 to 19.
// - The input direction register at 187h resets to ones and the input data at 107h reads zero after reset.
// - Reading a data register returns the pin levels and writing loads the output latch; the input data register at 107h has no latch and ignores writes.
// - Every set, clear and toggle write to 07h reads the pins, modifies the value and writes the whole result to the latches; a plain write stores the operand.
// - A read-modify-write stores the level of input pins into their latches for later driving.
`timescale 1ns/10ps
`default_nettype none
`include "dpio_defines.svh"

module dpio_port (
  // Clock and resets.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_rst_other,
  // Register file port from the core.
  input wire logic [8:0] i_addr,
  input wire logic i_rd_en,
  input wire logic i_wr_en,
  input wire dpio_pkg::dpio_op_t i_wr_op,
  input wire logic [7:0] i_wr_data,
  input wire logic [2:0] i_wr_bit,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Peripherals sharing the bidirectional pins.
  input wire logic i_timer_osc_en,
  input wire logic i_ccp_en,
  input wire logic i_ccp_drive,
  input wire logic i_ccp_out,
  input wire logic i_serial_en,
  input wire logic i_serial_master,
  input wire logic i_sck_out,
  input wire logic i_sdo_out,
  // Bidirectional pins.
  input wire logic [5:0] i_bidir_pin,
  output logic [5:0] o_bidir_out,
  output logic [5:0] o_bidir_oe,
  // Input-only pins and segment driver hand-off.
  input wire logic [7:0] i_input_pin,
  output logic [7:0] o_seg_drive_en,
  output logic [7:0] o_input_digital
);
  import dpio_pkg::*;

  // ****************************************************************
  // Storage and internal nets.
  // ****************************************************************
  logic [5:0] bidir_lat_ff;
  logic [5:0] bidir_dir_ff;
  logic [7:0] input_dir_ff;
  logic [7:0] seg_en_ff;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  logic [7:0] nxt_rd_data;
  logic [7:0] rmw_result;
  logic [5:0] ovr_en;
  logic [5:0] ovr_out;
  logic [5:0] ovr_val;
  logic [7:0] seg_owns;
  logic [7:0] input_read;
  logic wr_bidir_data;
  logic wr_bidir_dir;
  logic wr_input_dir;
  logic wr_seg_en;

  // ****************************************************************
  // Peripheral overrides of the bidirectional pins.
  // ****************************************************************

  // Oscillator pins go analog, so both are held as inputs while the oscillator runs.
  always_comb
  begin
    ovr_en = 6'h00;
    ovr_out = 6'h00;
    ovr_val = 6'h00;
    ovr_en[`DPIO_PIN_TMR_CKI] = i_timer_osc_en;
    ovr_en[`DPIO_PIN_TMR_OSI] = i_timer_osc_en;
    ovr_en[`DPIO_PIN_CCP] = i_ccp_en;
    ovr_out[`DPIO_PIN_CCP] = i_ccp_drive;
    ovr_val[`DPIO_PIN_CCP] = i_ccp_out;
    ovr_en[`DPIO_PIN_SCK] = i_serial_en;
    ovr_out[`DPIO_PIN_SCK] = i_serial_master;
    ovr_val[`DPIO_PIN_SCK] = i_sck_out;
    ovr_en[`DPIO_PIN_SDI] = i_serial_en;
    ovr_en[`DPIO_PIN_SDO] = i_serial_en;
    ovr_out[`DPIO_PIN_SDO] = 1'b1;
    ovr_val[`DPIO_PIN_SDO] = i_sdo_out;
  end

  // Per pin: an owning peripheral decides direction, else a zero direction bit drives.
  genvar gi;
  generate
    for (gi = 0; gi < `DPIO_BIDIR_W; gi++)
    begin : g_bidir
      assign o_bidir_oe[gi] = ovr_en[gi] ? ovr_out[gi] : ~bidir_dir_ff[gi];
      assign o_bidir_out[gi] = (ovr_en[gi] && ovr_out[gi]) ? ovr_val[gi] : bidir_lat_ff[gi];
    end
  endgenerate

  // ****************************************************************
  // Input-only port and segment ownership.
  // ****************************************************************

  // Only two enable bits reach this port, so each covers a nibble of pins.
  assign seg_owns = {{4{seg_en_ff[`DPIO_SEG_HIGH_BIT]}}, {4{seg_en_ff[`DPIO_SEG_LOW_BIT]}}};
  assign o_seg_drive_en = seg_owns;
  assign o_input_digital = ~seg_owns;
  // Segment-owned pins read low; this also gives the zero value seen after reset.
  assign input_read = i_input_pin & ~seg_owns;

  // ****************************************************************
  // Register read source and read-modify-write.
  // ****************************************************************

  // The data registers return pin levels, never the latches.
  always_comb
  begin
    case (i_addr)
      `DPIO_ADDR_BIDIR_DATA: nxt_rd_data = {2'b00, i_bidir_pin};
      `DPIO_ADDR_BIDIR_DIR: nxt_rd_data = {2'b00, bidir_dir_ff};
      `DPIO_ADDR_INPUT_DATA: nxt_rd_data = input_read;
      `DPIO_ADDR_SEG_ENABLE: nxt_rd_data = seg_en_ff;
      `DPIO_ADDR_INPUT_DIR: nxt_rd_data = input_dir_ff;
      default: nxt_rd_data = 8'h00;
    endcase
  end

  // The same read value feeds the modify stage, so input pins get their level latched.
  dpio_rmw_alu #(
    .W(8)
  ) u_alu (
    .i_op(i_wr_op),
    .i_src(nxt_rd_data),
    .i_operand(i_wr_data),
    .i_bit(i_wr_bit),
    .o_result(rmw_result)
  );

  // Write decodes; the input data register has no latch and ignores writes.
  assign wr_bidir_data = i_wr_en && (i_addr == `DPIO_ADDR_BIDIR_DATA);
  assign wr_bidir_dir = i_wr_en && (i_addr == `DPIO_ADDR_BIDIR_DIR);
  assign wr_input_dir = i_wr_en && (i_addr == `DPIO_ADDR_INPUT_DIR);
  assign wr_seg_en = i_wr_en && (i_addr == `DPIO_ADDR_SEG_ENABLE);

  // ****************************************************************
  // Registers.
  // ****************************************************************

  // The latch holds across non-power-on resets so outputs do not glitch on a restart.
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      bidir_lat_ff <= `DPIO_RST_BIDIR_LATCH;
    else if (wr_bidir_data && !i_rst_other)
      bidir_lat_ff <= rmw_result[5:0];
  end

  // Direction returns to all inputs on every reset.
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      bidir_dir_ff <= `DPIO_RST_BIDIR_DIR;
    else if (i_rst_other)
      bidir_dir_ff <= `DPIO_RST_BIDIR_DIR;
    else if (wr_bidir_dir)
      bidir_dir_ff <= rmw_result[5:0];
  end

  // Input port direction has no effect on pins but is kept for software.
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      input_dir_ff <= `DPIO_RST_INPUT_DIR;
    else if (i_rst_other)
      input_dir_ff <= `DPIO_RST_INPUT_DIR;
    else if (wr_input_dir)
      input_dir_ff <= rmw_result;
  end

  // Segment enable returns to all segments on every reset.
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      seg_en_ff <= `DPIO_RST_SEG_ENABLE;
    else if (i_rst_other)
      seg_en_ff <= `DPIO_RST_SEG_ENABLE;
    else if (wr_seg_en)
      seg_en_ff <= rmw_result;
  end

  // Read data is registered one cycle after the request.
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= i_rd_en;
      if (i_rd_en)
        rd_data_ff <= nxt_rd_data;
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_rd_bidir;
    i_rd_en && (i_addr == `DPIO_ADDR_BIDIR_DATA);
  endsequence

  sequence s_wr_bidir;
    wr_bidir_data && !i_rst_other;
  endsequence

  chk_dir_reset_ones: assert property (i_rst_other |=> bidir_dir_ff == 6'h3F && input_dir_ff == 8'hFF)
    else $error("direction not all ones after reset");
  chk_latch_keeps: assert property (i_rst_other |=> $stable(bidir_lat_ff))
    else $error("data latch changed on non-power-on reset");
  chk_rd_upper_zero: assert property (s_rd_bidir |=> o_rd_valid && o_rd_data[7:6] == 2'b00)
    else $error("upper bits not zero");
  chk_rd_pin_level: assert property (s_rd_bidir |=> o_rd_data[5:0] == $past(i_bidir_pin))
    else $error("read did not return pin levels");
  chk_periph_force: assert property (i_serial_en |->
    o_bidir_oe[5] && !o_bidir_oe[4] && o_bidir_oe[3] == i_serial_master)
    else $error("peripheral override ignored");
  chk_dir_bit_oe: assert property (!(i_timer_osc_en || i_ccp_en || i_serial_en) |->
    o_bidir_oe == ~bidir_dir_ff)
    else $error("direction bit not honoured");
  chk_seg_group: assert property (o_seg_drive_en == {{4{seg_en_ff[4]}}, {4{seg_en_ff[3]}}})
    else $error("segment grouping wrong");
  chk_seg_reads_low: assert property ((i_rd_en && i_addr == `DPIO_ADDR_INPUT_DATA) |=>
    (o_rd_data & $past(o_seg_drive_en)) == 8'h00)
    else $error("segment pin read as digital");
  chk_rmw_pins: assert property ((s_wr_bidir and (i_wr_op == DPIO_OP_SET)) |=>
    bidir_lat_ff == ($past(i_bidir_pin) | $past(6'(6'h01 << i_wr_bit))))
    else $error("bit set did not use pin levels");
  chk_seg_reset: assert property (i_rst_other |=> seg_en_ff == 8'hFF ##1 o_input_digital == 8'h00 || $changed(seg_en_ff))
    else $error("segment enable not reset");

  // Read and write steps are named once, each used by one property below,
  // so that the property does not repeat the address decode.
  sequence s_rd_any;
    i_rd_en;
  endsequence

  sequence s_rd_answer;
    o_rd_valid;
  endsequence

  sequence s_rd_input;
    i_rd_en && (i_addr == `DPIO_ADDR_INPUT_DATA);
  endsequence

  sequence s_wr_clear;
    wr_bidir_data && !i_rst_other && (i_wr_op == DPIO_OP_CLEAR);
  endsequence

  // Valid is a one-cycle answer; a longer level would let the core take one read twice.
  chk_rd_valid_once: assert property (s_rd_any |=> s_rd_answer)
    else $error("read answer missing");
  chk_rd_valid_idle: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("read answer without request");
  // Digital input pins hand their level straight through to the read data.
  chk_input_level: assert property (s_rd_input |=> o_rd_data == $past(i_input_pin & o_input_digital))
    else $error("digital input pin level lost");
  // A cleared bit also starts from the pin levels, so input pins pick up their level.
  chk_rmw_clear: assert property (s_wr_clear |=>
    bidir_lat_ff == ($past(i_bidir_pin) & ~$past(6'(6'h01 << i_wr_bit))))
    else $error("bit clear did not use pin levels");
  // Oscillator pins carry an analog swing, so they must never be driven.
  chk_timer_input: assert property (i_timer_osc_en |-> o_bidir_oe[1:0] == 2'b00)
    else $error("oscillator pin driven");
  chk_ccp_output: assert property ((i_ccp_en && i_ccp_drive) |-> o_bidir_oe[2] && o_bidir_out[2] == i_ccp_out)
    else $error("compare output not on its pin");
  // A pin is never both a segment driver and a digital input.
  chk_seg_excl: assert property ((o_seg_drive_en & o_input_digital) == 8'h00)
    else $error("pin both segment and digital");
  // With no peripheral active, every driven pin shows its latch.
  chk_latch_drive: assert property (!(i_timer_osc_en || i_ccp_en || i_serial_en) |->
    ((o_bidir_out ^ bidir_lat_ff) & o_bidir_oe) == 6'h00)
    else $error("driven pin does not show its latch");
endmodule : dpio_port

`default_nettype wire

// ---- dpio_pin_model.sv ----
/*
  Far-side circuitry on the dual pin port: external levels on the bidirectional and input-only pins.
  Assumes the bench supplies the external levels and the device supplies drive value and enable.
*/
`timescale 1ns/10ps
`default_nettype none

module dpio_pin_model (
  // Device side.
  input wire logic [5:0] i_out,
  input wire logic [5:0] i_oe,
  // Bench side.
  input wire logic [5:0] i_ext,
  input wire logic [7:0] i_ext_in,
  // Resolved pin levels.
  output logic [5:0] o_pin,
  output logic [7:0] o_in_pin
);
  // The far side lets go of every pin that the device drives, so no wired level fights it.
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
  assign o_in_pin = i_ext_in;
endmodule : dpio_pin_model

`default_nettype wire

// ---- dual_port_pin_io_with_segment_override_tb.sv ----
/*
  Self-checking bench for the dual pin port: registers, overrides, read-modify-write, resets.
  Assumes dpio_pkg and dpio_pin_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module dual_port_pin_io_with_segment_override_tb;
  import dpio_pkg::*;
  // ****************************************************************
  // Stimulus, pins and bookkeeping.
  // ****************************************************************
  logic clk = 1'b0, arst_n = 1'b0, rst_o = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
  logic [8:0] addr = 9'h000;
  dpio_op_t op = DPIO_OP_WRITE;
  logic [7:0] wd = 8'h00, rdat, seg_en, in_dig, ext_in = 8'h00, in_pin, d;
  logic [2:0] wb = 3'h0;
  logic tmr = 1'b0, ccp = 1'b0, ccp_dr = 1'b0, ccp_o = 1'b0, ser = 1'b0, mst = 1'b0, sck = 1'b0, sdo = 1'b0;
  logic rvalid;
  logic [5:0] pin, bout, boe, ext = 6'h00, lat, dir;
  logic [7:0] q[$];
  int bad_count = 0, n_tests = 0;

  always #10 clk = ~clk;

  dpio_port i_dpio_port (.i_clk_sys(clk), .i_arst_n(arst_n), .i_rst_other(rst_o), .i_addr(addr),
    .i_rd_en(rd_en), .i_wr_en(wr_en), .i_wr_op(op), .i_wr_data(wd), .i_wr_bit(wb), .o_rd_data(rdat),
    .o_rd_valid(rvalid), .i_timer_osc_en(tmr), .i_ccp_en(ccp), .i_ccp_drive(ccp_dr), .i_ccp_out(ccp_o),
    .i_serial_en(ser), .i_serial_master(mst), .i_sck_out(sck), .i_sdo_out(sdo), .i_bidir_pin(pin),
    .o_bidir_out(bout), .o_bidir_oe(boe), .i_input_pin(in_pin), .o_seg_drive_en(seg_en),
    .o_input_digital(in_dig));

  dpio_pin_model i_dpio_pin_model (.i_out(bout), .i_oe(boe), .i_ext(ext), .i_ext_in(ext_in), .o_pin(pin),
    .o_in_pin(in_pin));

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  // Reads note their expectation; the answer is checked when valid shows, mid-cycle.
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    #2 rd_en = 1'b1;
    addr = a;
    q.push_back(e);
    @(posedge clk);
    #2 rd_en = 1'b0;
  endtask : rd

  task automatic wr(input logic [8:0] a, input dpio_op_t o, input logic [7:0] v, input logic [2:0] b);
    @(posedge clk);
    #2 wr_en = 1'b1;
    addr = a;
    op = o;
    wd = v;
    wb = b;
    @(posedge clk);
    #2 wr_en = 1'b0;
  endtask : wr

  always @(negedge clk)
  begin
    if (rvalid === 1'b1)
    begin
      if (q.size() == 0)
        cmp("rd_valid", 8'h00, 8'h01);
      else
        cmp("rd_data", q.pop_front(), rdat);
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // A hang is cut well past the under one hundred cycles the sequence needs.
  initial
  begin
    #40000;
    bad_count++;
    end_sim();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    void'($urandom(32'hA1CD));
    ext = 6'($urandom);
    ext_in = 8'($urandom);
    {ccp_o, sck, sdo} = 3'($urandom);
    repeat (16) @(posedge clk);
    #2 arst_n = 1'b1;
    rd(9'h087, 8'h3F);
    rd(9'h10D, 8'hFF);
    rd(9'h187, 8'hFF);
    rd(9'h107, 8'h00);
    rd(9'h007, {2'b00, ext});
    rd(9'h1FF, 8'h00);
    wr(9'h087, DPIO_OP_WRITE, 8'hCF, 3'h0);
    rd(9'h087, 8'h0F);
    cmp("oe", 8'h30, {2'b00, boe});
    d = 8'($urandom);
    wr(9'h007, DPIO_OP_WRITE, d, 3'h0);
    lat = d[5:0];
    cmp("out_hi", {6'h00, lat[5:4]}, {6'h00, bout[5:4]});
    wr(9'h007, DPIO_OP_SET, 8'h00, 3'h5);
    lat = {lat[5:4], ext[3:0]} | 6'h20;
    ext = ~ext;
    wr(9'h087, DPIO_OP_WRITE, 8'h00, 3'h0);
    cmp("latch", {2'b00, lat}, {2'b00, bout});
    d = 8'($urandom);
    wr(9'h007, DPIO_OP_TOGGLE, d, 3'h0);
    lat = lat ^ d[5:0];
    cmp("latch", {2'b00, lat}, {2'b00, bout});
    wr(9'h007, DPIO_OP_CLEAR, 8'h00, 3'h1);
    lat[1] = 1'b0;
    cmp("latch", {2'b00, lat}, {2'b00, bout});
    wr(9'h087, DPIO_OP_SET, 8'h00, 3'h3);
    cmp("oe", 8'h37, {2'b00, boe});
    wr(9'h087, DPIO_OP_CLEAR, 8'h00, 3'h3);
    @(posedge clk);
    #2 {tmr, ccp, ser} = 3'b111;
    #2 cmp("per_oe", 8'h20, {2'b00, boe});
    wr(9'h087, DPIO_OP_WRITE, 8'h3F, 3'h0);
    @(posedge clk);
    #2 {ccp_dr, mst} = 2'b11;
    #2 cmp("per_oe", 8'h2C, {2'b00, boe});
    cmp("per_out", {5'h00, sdo, sck, ccp_o}, {5'h00, bout[5], bout[3:2]});
    @(posedge clk);
    #2 {tmr, ccp, ser, ccp_dr, mst} = 5'h00;
    wr(9'h10D, DPIO_OP_WRITE, 8'h00, 3'h0);
    cmp("seg_en", 8'h00, seg_en);
    cmp("digital", 8'hFF, in_dig);
    rd(9'h107, ext_in);
    wr(9'h10D, DPIO_OP_WRITE, 8'h08, 3'h0);
    cmp("seg_en", 8'h0F, seg_en);
    rd(9'h107, ext_in & 8'hF0);
    wr(9'h187, DPIO_OP_WRITE, 8'h00, 3'h0);
    rd(9'h187, 8'h00);
    // A write landing with the other reset must be dropped.
    @(posedge clk);
    #2 {rst_o, wr_en} = 2'b11;
    addr = 9'h007;
    wd = {2'b00, ~lat};
    @(posedge clk);
    #2 {rst_o, wr_en} = 2'b00;
    rd(9'h087, 8'h3F);
    rd(9'h10D, 8'hFF);
    rd(9'h187, 8'hFF);
    wr(9'h087, DPIO_OP_WRITE, 8'h00, 3'h0);
    cmp("latch", {2'b00, lat}, {2'b00, bout});
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule : dual_port_pin_io_with_segment_override_tb

`default_nettype wire
